// *** wdsup_pkg.sv ***
// Package for the watchdog supervisor: timing counts, bit positions, reset values.
// Assumes a single system clock; no bus, all control bits are plain ports.
`default_nettype none

package wdsup_pkg;
  // Clock rate
  localparam int CLK_HZ = 10_000_000;
  // Extra window after the interrupt timeout, in clocks
  localparam int RESET_WINDOW_CLKS = 512;
  // Interrupt timeout exponents for select codes 00..11
  localparam int TMO_EXP_SEL0 = 16;
  localparam int TMO_EXP_SEL1 = 19;
  localparam int TMO_EXP_SEL2 = 22;
  localparam int TMO_EXP_SEL3 = 25;
  // Counter width: covers 2^25 + 512
  localparam int CNT_W = 26;
  // Bit positions of the documented control bits in their registers
  localparam int IRQ_FLAG_BIT = 3;     // ext_interrupt_control_reg
  localparam int RUN_ENABLE_BIT = 1;   // ext_interrupt_control_reg
  localparam int RESTART_BIT = 0;      // ext_interrupt_control_reg
  localparam int RST_FLAG_BIT = 2;     // watchdog_control_reg
  localparam int SEL_HI_BIT = 7;       // clock_control_reg
  localparam int SEL_LO_BIT = 6;       // clock_control_reg
  localparam int IRQ_ENABLE_BIT = 4;   // ext_interrupt_enable_reg
  // Reset values
  localparam logic RUN_ENABLE_RST = 1'b0;
  localparam logic IRQ_ENABLE_RST = 1'b0;
  localparam logic IRQ_FLAG_RST = 1'b0;
  localparam logic [1:0] SEL_RST = 2'h0;
  // Phases of the watchdog
  typedef enum logic [1:0] {WDS_COUNT, WDS_WINDOW, WDS_EXPIRED} wdsup_phase_t;
endpackage : wdsup_pkg

`default_nettype wire

// *** wdsup_limit.sv ***
// Timeout comparator: turns the period select into the interrupt and reset limits.
// Assumes the selection is from registers on the same clock.
`timescale 1ns/10ps
`default_nettype none

module wdsup_limit #(
  parameter int CNT_W = wdsup_pkg::CNT_W
) (
  // Selection and count
  input wire logic [1:0] sel_in,
  input wire logic [CNT_W-1:0] count_in,
  // Limit hits
  output logic irq_hit_out,
  output logic rst_hit_out
);
  logic [CNT_W-1:0] irq_limit;
  logic [CNT_W-1:0] rst_limit;

  // Four periods 2^16, 2^19, 2^22, 2^25; reset limit is 512 later
  always_comb begin
    unique case (sel_in)
      2'b00: irq_limit = CNT_W'(1) << wdsup_pkg::TMO_EXP_SEL0;
      2'b01: irq_limit = CNT_W'(1) << wdsup_pkg::TMO_EXP_SEL1;
      2'b10: irq_limit = CNT_W'(1) << wdsup_pkg::TMO_EXP_SEL2;
      2'b11: irq_limit = CNT_W'(1) << wdsup_pkg::TMO_EXP_SEL3;
    endcase
    rst_limit = irq_limit + CNT_W'(wdsup_pkg::RESET_WINDOW_CLKS);
  end

  // Exact compare; counter reaches each value once per period
  assign irq_hit_out = (count_in == irq_limit);
  assign rst_hit_out = (count_in == rst_limit);
endmodule // wdsup_limit

`default_nettype wire

// *** wdsup_top.sv ***
// Watchdog supervisor core: counter, timeout flag, reset flag and processor reset.
// Assumes software writes arrive as one-cycle strobes from the special function
// register logic on the same clock; the external reset pin is already synchronised.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Reaching selected interrupt timeout sets the timeout interrupt flag.
// - Interrupt request stays raised while the flag remains set.
// - External reset or watchdog reset clears the interrupt flag.
// - 512 clocks past timeout without restart: processor reset, set reset flag.
// - Writing zero to set reset flag resets the counter.
// - Writing zero clears reset flag; flag survives the reset it caused.
// - Counter runs only while run enable is set.
// - External reset clears run enable.
// - Clearing enable holds the count; re-enabling resumes from there.
// - Restart resets counter only when irq flag set and reset flag clear.
// - Restart before timeout is ignored, counter unchanged; here it still clears the count if software has set the irq flag.
// - Two select bits choose among four interrupt timeout periods.
// - Interrupt requested only when watchdog interrupt enable is set.
// - Watchdog or external reset clears the interrupt enable.
// - Periods 2^16, 2^19, 2^22, 2^25; reset period adds 512.
module wdsup_top #(
  parameter int CNT_W = wdsup_pkg::CNT_W
) (
  // Clock and external reset pin
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  // Run enable writes
  input wire logic RUN_ENABLE_WR_IN,
  input wire logic RUN_ENABLE_DATA_IN,
  // Restart strobe
  input wire logic RESTART_WR_IN,
  // Interrupt flag writes
  input wire logic IRQ_FLAG_WR_IN,
  input wire logic IRQ_FLAG_DATA_IN,
  // Reset flag writes
  input wire logic RST_FLAG_WR_IN,
  input wire logic RST_FLAG_DATA_IN,
  // Period select writes
  input wire logic PERIOD_SEL_WR_IN,
  input wire logic PERIOD_SEL_HI_IN,
  input wire logic PERIOD_SEL_LO_IN,
  // Interrupt enable writes
  input wire logic IRQ_ENABLE_WR_IN,
  input wire logic IRQ_ENABLE_DATA_IN,
  // Status
  output logic WD_RUN_ENABLE_OUT,
  output logic WD_IRQ_ENABLE_OUT,
  output logic WD_TIMEOUT_IRQ_FLAG_OUT,
  output logic WD_RESET_OCCURRED_FLAG_OUT,
  output logic WD_PERIOD_SEL_HI_OUT,
  output logic WD_PERIOD_SEL_LO_OUT,
  output logic [CNT_W-1:0] WD_COUNT_OUT,
  // Interrupt request and processor reset
  output logic WD_IRQ_OUT,
  output logic WD_CPU_RESET_OUT
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic run_enable;
    logic irq_enable;
    logic irq_flag;
    logic rst_flag;
    logic [1:0] sel;
    logic cpu_reset;
    wdsup_pkg::wdsup_phase_t phase;
  } wdsup_state_t;

  wdsup_state_t st_r;
  wdsup_state_t st_nxt;
  logic irq_hit;
  logic rst_hit;

  // Limits from the selected period
  wdsup_limit #(
    .CNT_W(CNT_W)
  ) u_limit (
    .sel_in(st_r.sel),
    .count_in(st_r.count),
    .irq_hit_out(irq_hit),
    .rst_hit_out(rst_hit)
  );

  // Next state; hardware sets win over software clears in the same cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.cpu_reset = 1'b0;
    // Software register writes
    if (RUN_ENABLE_WR_IN) begin
      st_nxt.run_enable = RUN_ENABLE_DATA_IN;
    end
    if (IRQ_ENABLE_WR_IN) begin
      st_nxt.irq_enable = IRQ_ENABLE_DATA_IN;
    end
    if (PERIOD_SEL_WR_IN) begin
      st_nxt.sel = {PERIOD_SEL_HI_IN, PERIOD_SEL_LO_IN};
    end
    if (IRQ_FLAG_WR_IN) begin
      st_nxt.irq_flag = IRQ_FLAG_DATA_IN; // Flag persists until software, a watchdog reset or the external pin clears it
    end
    // Counter advances only while enabled; holds otherwise
    // Also steps in the cycle after a watchdog reset, so no clock is lost
    if (st_r.run_enable) begin
      st_nxt.count = st_r.count + CNT_W'(1);
    end
    // Interrupt timeout reached
    if (st_r.run_enable && irq_hit && st_r.phase == wdsup_pkg::WDS_COUNT) begin
      st_nxt.irq_flag = 1'b1;
      st_nxt.phase = wdsup_pkg::WDS_WINDOW;
    end
    // Restart valid only while irq flag set and reset flag clear; other writes change nothing
    if (RESTART_WR_IN && st_r.irq_flag && !st_r.rst_flag) begin
      st_nxt.count = '0;
      st_nxt.phase = wdsup_pkg::WDS_COUNT;
    end // Otherwise ignored
    // Zero written to reset flag: clear it, and resync the counter if it was set
    if (RST_FLAG_WR_IN && !RST_FLAG_DATA_IN) begin
      st_nxt.rst_flag = 1'b0;
      if (st_r.rst_flag) begin
        st_nxt.count = '0;
        st_nxt.phase = wdsup_pkg::WDS_COUNT;
      end
    end
    // Window expired: processor reset, counter cleared, irq state cleared
    if (st_r.run_enable && rst_hit && st_r.phase == wdsup_pkg::WDS_WINDOW) begin
      st_nxt.cpu_reset = 1'b1;
      st_nxt.rst_flag = 1'b1; // Survives its own reset
      st_nxt.irq_flag = 1'b0;
      st_nxt.irq_enable = 1'b0;
      st_nxt.count = '0;
      st_nxt.phase = wdsup_pkg::WDS_EXPIRED;
    end
    // After a watchdog reset, counting resumes from zero
    if (st_r.phase == wdsup_pkg::WDS_EXPIRED && !RST_FLAG_WR_IN) begin
      st_nxt.phase = wdsup_pkg::WDS_COUNT;
    end
  end

  // State register; the external pin clears enables, irq flag and counter, keeps the reset flag
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      st_r.count <= '0;
      st_r.run_enable <= wdsup_pkg::RUN_ENABLE_RST;
      st_r.irq_enable <= wdsup_pkg::IRQ_ENABLE_RST;
      st_r.irq_flag <= wdsup_pkg::IRQ_FLAG_RST;
      st_r.rst_flag <= st_r.rst_flag; // Kept so boot code sees reset source
      st_r.sel <= wdsup_pkg::SEL_RST;
      st_r.cpu_reset <= 1'b0;
      st_r.phase <= wdsup_pkg::WDS_COUNT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from registers; irq is level while flag and enable hold
  assign WD_RUN_ENABLE_OUT = st_r.run_enable;
  assign WD_IRQ_ENABLE_OUT = st_r.irq_enable;
  assign WD_TIMEOUT_IRQ_FLAG_OUT = st_r.irq_flag;
  assign WD_RESET_OCCURRED_FLAG_OUT = st_r.rst_flag;
  assign WD_PERIOD_SEL_HI_OUT = st_r.sel[1];
  assign WD_PERIOD_SEL_LO_OUT = st_r.sel[0];
  assign WD_COUNT_OUT = st_r.count;
  assign WD_IRQ_OUT = st_r.irq_flag & st_r.irq_enable;
  assign WD_CPU_RESET_OUT = st_r.cpu_reset;
endmodule // wdsup_top

`default_nettype wire

// *** wdsup_sva.sv ***
// Checker for the watchdog supervisor: flag, count and reset-pulse timing.
// Assumes it is bound to wdsup_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module wdsup_sva #(
  parameter int CNT_W = wdsup_pkg::CNT_W
) (
  // Clock, reset and strobes
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic RESTART_WR_IN,
  input wire logic RST_FLAG_WR_IN,
  input wire logic RST_FLAG_DATA_IN,
  // Watched outputs
  input wire logic WD_RUN_ENABLE_OUT,
  input wire logic WD_IRQ_ENABLE_OUT,
  input wire logic WD_TIMEOUT_IRQ_FLAG_OUT,
  input wire logic WD_RESET_OCCURRED_FLAG_OUT,
  input wire logic WD_PERIOD_SEL_HI_OUT,
  input wire logic WD_PERIOD_SEL_LO_OUT,
  input wire logic [CNT_W-1:0] WD_COUNT_OUT,
  input wire logic WD_IRQ_OUT,
  input wire logic WD_CPU_RESET_OUT
);
  // Limit for the current select; the reset point lies 512 further
  logic [CNT_W-1:0] lim;
  assign lim = CNT_W'(1) << (16 + 3 * {WD_PERIOD_SEL_HI_OUT, WD_PERIOD_SEL_LO_OUT});
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  chk_flag_on_limit: assert property (WD_RUN_ENABLE_OUT && WD_COUNT_OUT == lim |=> WD_TIMEOUT_IRQ_FLAG_OUT)
    else $error("flag late");
  chk_cpu_reset_time: assert property (WD_RUN_ENABLE_OUT && WD_COUNT_OUT == lim + 512
    |=> WD_CPU_RESET_OUT && WD_RESET_OCCURRED_FLAG_OUT) else $error("reset late");
  chk_reset_clears: assert property (WD_CPU_RESET_OUT |-> !WD_TIMEOUT_IRQ_FLAG_OUT && !WD_IRQ_ENABLE_OUT
    && WD_COUNT_OUT == 0) else $error("reset state");
  chk_hold_disabled: assert property (!WD_RUN_ENABLE_OUT && !RESTART_WR_IN && !RST_FLAG_WR_IN
    |=> $stable(WD_COUNT_OUT)) else $error("count moved");
  chk_count_step: assert property (WD_RUN_ENABLE_OUT && !RST_FLAG_WR_IN && !(RESTART_WR_IN && WD_TIMEOUT_IRQ_FLAG_OUT)
    && WD_COUNT_OUT != lim + 512 |=> WD_COUNT_OUT == $past(WD_COUNT_OUT) + 1'b1) else $error("bad step");
  chk_irq_level: assert property (WD_IRQ_OUT == (WD_TIMEOUT_IRQ_FLAG_OUT && WD_IRQ_ENABLE_OUT))
    else $error("irq level");
  chk_ext_reset: assert property (disable iff (1'b0) RST_IN |=> !WD_RUN_ENABLE_OUT && !WD_IRQ_ENABLE_OUT
    && !WD_TIMEOUT_IRQ_FLAG_OUT && WD_COUNT_OUT == 0) else $error("pin reset");
  chk_resync_clear: assert property (RST_FLAG_WR_IN && !RST_FLAG_DATA_IN && WD_RESET_OCCURRED_FLAG_OUT
    |=> !WD_RESET_OCCURRED_FLAG_OUT && WD_COUNT_OUT == 0) else $error("resync");
endmodule // wdsup_sva
bind wdsup_top wdsup_sva #(.CNT_W(CNT_W)) u_wdsup_sva (.CORE_CLK_IN, .RST_IN, .RESTART_WR_IN, .RST_FLAG_WR_IN,
  .RST_FLAG_DATA_IN, .WD_RUN_ENABLE_OUT, .WD_IRQ_ENABLE_OUT, .WD_TIMEOUT_IRQ_FLAG_OUT, .WD_RESET_OCCURRED_FLAG_OUT,
  .WD_PERIOD_SEL_HI_OUT, .WD_PERIOD_SEL_LO_OUT, .WD_COUNT_OUT, .WD_IRQ_OUT, .WD_CPU_RESET_OUT);
`default_nettype wire

// *** wdsup_bench.sv ***
// Bench: reference model stepped each edge, all outputs compared each cycle.
// Assumes package, design and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module wdsup_bench;
  logic CORE_CLK_IN = 0, RST_IN = 1, RUN_ENABLE_WR_IN = 0, RUN_ENABLE_DATA_IN = 0, RESTART_WR_IN = 0;
  logic IRQ_FLAG_WR_IN = 0, IRQ_FLAG_DATA_IN = 0, RST_FLAG_WR_IN = 0, RST_FLAG_DATA_IN = 0, PERIOD_SEL_WR_IN = 0;
  logic PERIOD_SEL_HI_IN = 0, PERIOD_SEL_LO_IN = 0, IRQ_ENABLE_WR_IN = 0, IRQ_ENABLE_DATA_IN = 0;
  logic WD_RUN_ENABLE_OUT, WD_IRQ_ENABLE_OUT, WD_TIMEOUT_IRQ_FLAG_OUT, WD_RESET_OCCURRED_FLAG_OUT;
  logic WD_PERIOD_SEL_HI_OUT, WD_PERIOD_SEL_LO_OUT, WD_IRQ_OUT, WD_CPU_RESET_OUT;
  logic [wdsup_pkg::CNT_W-1:0] WD_COUNT_OUT;
  // Model state; the reset flag starts unknown, as it has no reset value
  int m_cnt = 0, m_lim, fails = 0, comparisons = 0, i;
  logic m_en = 0, m_ie = 0, m_if = 0, m_rf = 1'bx, m_res = 0, m_hit, go = 0;
  logic [1:0] m_sel = 0;
  wdsup_top u_wdsup_top (.CORE_CLK_IN, .RST_IN, .RUN_ENABLE_WR_IN, .RUN_ENABLE_DATA_IN, .RESTART_WR_IN,
    .IRQ_FLAG_WR_IN, .IRQ_FLAG_DATA_IN, .RST_FLAG_WR_IN, .RST_FLAG_DATA_IN, .PERIOD_SEL_WR_IN, .PERIOD_SEL_HI_IN,
    .PERIOD_SEL_LO_IN, .IRQ_ENABLE_WR_IN, .IRQ_ENABLE_DATA_IN, .WD_RUN_ENABLE_OUT, .WD_IRQ_ENABLE_OUT,
    .WD_TIMEOUT_IRQ_FLAG_OUT, .WD_RESET_OCCURRED_FLAG_OUT, .WD_PERIOD_SEL_HI_OUT, .WD_PERIOD_SEL_LO_OUT,
    .WD_COUNT_OUT, .WD_IRQ_OUT, .WD_CPU_RESET_OUT);
  always #50 CORE_CLK_IN = ~CORE_CLK_IN;
  // Reference model; reads inputs before this edge's updates land
  always @(posedge CORE_CLK_IN) begin
    m_lim = 1 << (16 + 3 * m_sel);
    m_res = 0;
    if (RST_IN) begin
      {m_cnt, m_en, m_ie, m_if, m_sel} = 0;
    end else if (m_en && m_cnt == m_lim + 512) begin
      m_res = 1;
      m_rf = 1;
      {m_cnt, m_ie, m_if} = 0;
    end else begin
      m_hit = m_en && m_cnt == m_lim;
      if ((RESTART_WR_IN && m_if && m_rf === 0) || (RST_FLAG_WR_IN && !RST_FLAG_DATA_IN && m_rf === 1)) m_cnt = 0;
      else if (m_en) m_cnt++;
      if (m_hit) m_if = 1;
      else if (IRQ_FLAG_WR_IN) m_if = IRQ_FLAG_DATA_IN;
      if (RST_FLAG_WR_IN && !RST_FLAG_DATA_IN) m_rf = 0;
      if (RUN_ENABLE_WR_IN) m_en = RUN_ENABLE_DATA_IN;
      if (IRQ_ENABLE_WR_IN) m_ie = IRQ_ENABLE_DATA_IN;
      if (PERIOD_SEL_WR_IN) m_sel = {PERIOD_SEL_HI_IN, PERIOD_SEL_LO_IN};
    end
  end
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (fails == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Strobes and data in one word, applied at an edge; flag data bits on top
  task automatic drive(input logic [11:0] v);
    {IRQ_FLAG_DATA_IN, RST_FLAG_DATA_IN, RUN_ENABLE_WR_IN, RUN_ENABLE_DATA_IN, RESTART_WR_IN, IRQ_FLAG_WR_IN,
      RST_FLAG_WR_IN, PERIOD_SEL_WR_IN, PERIOD_SEL_HI_IN, PERIOD_SEL_LO_IN, IRQ_ENABLE_WR_IN,
      IRQ_ENABLE_DATA_IN} <= v;
    @(posedge CORE_CLK_IN);
  endtask
  // Outputs are settled at the falling edge
  always @(negedge CORE_CLK_IN) if (go) check({WD_RUN_ENABLE_OUT, WD_IRQ_ENABLE_OUT, WD_TIMEOUT_IRQ_FLAG_OUT,
    WD_RESET_OCCURRED_FLAG_OUT, WD_PERIOD_SEL_HI_OUT, WD_PERIOD_SEL_LO_OUT, WD_COUNT_OUT, WD_IRQ_OUT,
    WD_CPU_RESET_OUT}, {m_en, m_ie, m_if, m_rf, m_sel, m_cnt[25:0], m_if & m_ie, m_res});
  // Hang guard, a little beyond one full timeout
  initial begin
    #(70_500 * 100);
    fails++;
    final_report();
  end
  initial begin
    void'($urandom(32'hb5633ca5));
    @(posedge CORE_CLK_IN);
    go <= 1;
    repeat (4) @(posedge CORE_CLK_IN);
    RST_IN <= 0;
    drive(12'h020);
    // Random writes, far below any limit: restarts count only with the flag set by software
    for (i = 0; i < 300; i++) drive(12'($urandom));
    // Shortest period, interrupt on, run to the processor reset
    drive(12'h313);
    drive(12'h000);
    for (i = 0; i < 70000 && WD_CPU_RESET_OUT !== 1'b1; i++) @(posedge CORE_CLK_IN);
    check(34'(WD_CPU_RESET_OUT), 34'h1);
    // Flag set by software, but the reset flag is still set: restart refused
    drive(12'h840);
    drive(12'h080);
    drive(12'h000);
    drive(12'h020);
    drive(12'h000);
    RST_IN <= 1;
    drive(12'h000);
    RST_IN <= 0;
    drive(12'h000);
    drive(12'h000);
    final_report();
  end
endmodule // wdsup_bench
`default_nettype wire
